//--- hdl/mode_access_channel_arbiter.sv
// mode access channel arbiter: permissions, ownership, lock and stop handling
//
// Overview of operation
// - Manual comes from any channel, POINT_TO_POINT_MODE/speed/gear/referencing from local or fieldbus, setup from local only.
// - Five operating modes and the setup mode are held one-hot so at most one mode is active at once; the utility mode sets utility_active instead.
// - Electronic gear mode is refused unless the expansion slot one module is present.
// - After a channel sets a mode, other channels are blocked until its active commands finish.
// - A stop request from any channel is always accepted and acted on.
// - The 16-bit lock resets to 0; 0 lets local units or fieldbus set modes, 1 only the fieldbus.
// - Local channels return when the fieldbus clears the lock or fieldbus operation is lost.
// - The requester is tracked as local serial, fieldbus or discrete I/O channel.
// - The data-collection utility exists from power-up and stays idle until the local tool starts it.
`timescale 1ns/10ps
`include "mode_arbiter_defines.svh"

module mode_access_channel_arbiter
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        mode_req_valid,
    input  wire logic [1:0]  mode_req_channel,
    input  wire logic [2:0]  mode_req_mode,
    input  wire logic [2:0]  channel_busy,
    input  wire logic [2:0]  stop_req,
    input  wire logic        expansion_slot_one_present,
    input  wire logic        fieldbus_alive,
    input  wire logic        utility_start,
    input  wire logic        lock_wr_en,
    input  wire logic [15:0] lock_wr_data,
    input  wire logic        pos_wr_en,
    input  wire logic [31:0] pos_wr_data,
    output logic             mode_grant,
    output logic             mode_refuse,
    output logic             stop_active,
    output logic [6:0]       active_mode,
    output logic             owner_valid,
    output logic [1:0]       owner_channel,
    output logic [15:0]      channel_access_lock,
    output logic [31:0]      absolute_target_position,
    output logic             utility_active
);

    //--------------------------------------------------------------
    // input synchronisers for pin-level inputs
    //--------------------------------------------------------------
    logic [2:0] stop_meta_reg;
    logic [2:0] stop_sync_reg;
    logic       slot_meta_reg;
    logic       slot_sync_reg;
    logic       alive_meta_reg;
    logic       alive_sync_reg;

    // two flops before any logic reads stop, slot presence and link health
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stop_meta_reg  <= 3'h0;
            stop_sync_reg  <= 3'h0;
            slot_meta_reg  <= 1'h0;
            slot_sync_reg  <= 1'h0;
            alive_meta_reg <= 1'h0;
            alive_sync_reg <= 1'h0;
        end
        else
        begin
            stop_meta_reg  <= stop_req;
            stop_sync_reg  <= stop_meta_reg;
            slot_meta_reg  <= expansion_slot_one_present;
            slot_sync_reg  <= slot_meta_reg;
            alive_meta_reg <= fieldbus_alive;
            alive_sync_reg <= alive_meta_reg;
        end
    end

    //--------------------------------------------------------------
    // request decode
    //--------------------------------------------------------------
    mode_arbiter_pkg::state_type state_reg;
    mode_arbiter_pkg::state_type state_next;
    logic                        alive_prev_reg;
    logic                        link_lost;
    logic                        permitted;
    logic                        lock_blocks;
    logic                        owner_blocks;
    logic                        owner_idle;
    logic [2:0]                  req_onehot_idx;

    // channel/mode permission table
    always_comb
    begin
        permitted = 1'b0;
        unique case (mode_req_mode)
            mode_arbiter_pkg::mode_manual:
                permitted = (mode_req_channel != 2'h3);
            mode_arbiter_pkg::mode_speed,
            mode_arbiter_pkg::mode_ptp,
            mode_arbiter_pkg::mode_ref:
                permitted = (mode_req_channel == `CHANNEL_LOCAL)
                         || (mode_req_channel == `CHANNEL_FIELDBUS);
            mode_arbiter_pkg::mode_gear:
                permitted = ((mode_req_channel == `CHANNEL_LOCAL)
                         || (mode_req_channel == `CHANNEL_FIELDBUS))
                         && slot_sync_reg;
            mode_arbiter_pkg::mode_setup,
            mode_arbiter_pkg::mode_utility:
                permitted = (mode_req_channel == `CHANNEL_LOCAL);
            default:
                permitted = 1'b0;
        endcase
    end

    // lock restricts non-fieldbus requesters; ownership blocks other channels
    assign link_lost      = alive_prev_reg && !alive_sync_reg;
    assign lock_blocks    = (state_reg.channel_access_lock == `LOCK_FIELDBUS)
                         && (mode_req_channel != `CHANNEL_FIELDBUS);
    assign owner_idle     = !channel_busy[state_reg.owner];
    assign owner_blocks   = state_reg.owner_valid && !owner_idle
                         && (mode_req_channel != state_reg.owner);
    assign req_onehot_idx = mode_req_mode;

    //--------------------------------------------------------------
    // next-state logic
    //--------------------------------------------------------------
    always_comb
    begin
        state_next        = state_reg;
        state_next.grant  = 1'b0;
        state_next.refuse = 1'b0;
        state_next.stop   = |stop_sync_reg;
        if (lock_wr_en)
            state_next.channel_access_lock = lock_wr_data;
        if (link_lost)
            state_next.channel_access_lock = `LOCK_RESET;
        if (pos_wr_en)
            state_next.absolute_target_position = pos_wr_data;
        if (state_reg.owner_valid && owner_idle)
            state_next.owner_valid = 1'b0;
        if (|stop_sync_reg)
        begin
            state_next.active_mode = `MODE_ONEHOT_RESET;
            state_next.owner_valid = 1'b0;
        end
        else if (mode_req_valid)
        begin
            if (permitted && !lock_blocks && !owner_blocks)
            begin
                state_next.grant = 1'b1;
                if (mode_req_mode == mode_arbiter_pkg::mode_utility)
                    state_next.utility_active = 1'b1;
                else
                begin
                    state_next.active_mode = 7'h01 << req_onehot_idx;
                    state_next.owner_valid = 1'b1;
                    state_next.owner = mode_arbiter_pkg::channel_type'(mode_req_channel);
                end
            end
            else
                state_next.refuse = 1'b1;
        end
        if (utility_start)
            state_next.utility_active = 1'b1;
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg.channel_access_lock      <= `LOCK_RESET;
            state_reg.absolute_target_position <= `POS_RESET;
            state_reg.active_mode              <= `MODE_ONEHOT_RESET;
            state_reg.owner_valid              <= 1'b0;
            state_reg.owner                    <= mode_arbiter_pkg::chan_local;
            state_reg.grant                    <= 1'b0;
            state_reg.refuse                   <= 1'b0;
            state_reg.stop                     <= 1'b0;
            state_reg.utility_active           <= 1'b0;
            alive_prev_reg                     <= 1'b0;
        end
        else
        begin
            state_reg      <= state_next;
            alive_prev_reg <= alive_sync_reg;
        end
    end

    //--------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------
    assign mode_grant               = state_reg.grant;
    assign mode_refuse              = state_reg.refuse;
    assign stop_active              = state_reg.stop;
    assign active_mode              = state_reg.active_mode;
    assign owner_valid              = state_reg.owner_valid;
    assign owner_channel            = state_reg.owner;
    assign channel_access_lock      = state_reg.channel_access_lock;
    assign absolute_target_position = state_reg.absolute_target_position;
    assign utility_active           = state_reg.utility_active;

endmodule

//--- shared/mode_arbiter_defines.svh
// constants of the mode access channel arbiter
`ifndef MODE_ARBITER_DEFINES_SVH
`define MODE_ARBITER_DEFINES_SVH
`define LOCK_WIDTH        16
`define LOCK_RESET        16'h0000
`define LOCK_FIELDBUS     16'h0001
`define POS_WIDTH         32
`define POS_RESET         32'h0000_0000
`define CHANNEL_LOCAL     2'h0
`define CHANNEL_FIELDBUS  2'h1
`define CHANNEL_IO        2'h2
`define MODE_ONEHOT_RESET 7'h00
`endif

//--- shared/mode_arbiter_pkg.sv
// types of the mode access channel arbiter
package mode_arbiter_pkg;
    // requesting channel
    typedef enum logic [1:0] {
        chan_local    = 2'h0,
        chan_fieldbus = 2'h1,
        chan_io       = 2'h2
    } channel_type;

    // requested mode, index into the one-hot active mode vector except mode_utility
    typedef enum logic [2:0] {
        mode_manual   = 3'h0,
        mode_speed    = 3'h1,
        mode_ptp      = 3'h2,
        mode_gear     = 3'h3,
        mode_ref      = 3'h4,
        mode_setup    = 3'h5,
        mode_utility  = 3'h6
    } mode_type;

    // arbiter state
    typedef struct packed {
        logic [15:0] channel_access_lock;
        logic [31:0] absolute_target_position;
        logic [6:0]  active_mode;
        logic        owner_valid;
        channel_type owner;
        logic        grant;
        logic        refuse;
        logic        stop;
        logic        utility_active;
    } state_type;
endpackage

//--- sim/mode_arbiter_monitor.sv
// concurrent checks on the arbiter ports
`timescale 1ns/10ps
module mode_arbiter_monitor
(
    input wire logic clk_sys, rst_n, mode_req_valid, mode_grant, mode_refuse,
    input wire logic stop_active, owner_valid, utility_active, expansion_slot_one_present,
    input wire logic [1:0]  mode_req_channel, owner_channel,
    input wire logic [2:0]  mode_req_mode, channel_busy, stop_req,
    input wire logic [6:0]  active_mode,
    input wire logic [15:0] channel_access_lock
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ---------------------------------------------
    // sequences
    // ---------------------------------------------
    sequence stop_held; (|stop_req)[*3]; endsequence
    sequence gear_no_slot;
        (!expansion_slot_one_present)[*4] ##0 (mode_req_valid && mode_req_mode == 3'h3);
    endsequence
    one_answer_a: assert property (!(mode_grant && mode_refuse)) else $error("grant and refuse");
    one_mode_a: assert property ($onehot0(active_mode)) else $error("mode not one-hot");
    io_manual_only_a: assert property (mode_req_valid && mode_req_channel == 2'h2
        && mode_req_mode != 3'h0 |=> !mode_grant) else $error("io mode granted");
    setup_local_a: assert property (mode_req_valid && mode_req_mode == 3'h5
        && mode_req_channel != 2'h0 |=> !mode_grant) else $error("setup granted");
    gear_slot_a: assert property (gear_no_slot |=> !mode_grant) else $error("gear granted");
    lock_refuse_a: assert property (mode_req_valid && channel_access_lock == 16'h0001
        && mode_req_channel != 2'h1 |=> !mode_grant) else $error("lock ignored");
    owner_block_a: assert property (mode_req_valid && owner_valid && channel_busy[owner_channel]
        && mode_req_channel != owner_channel |=> !mode_grant) else $error("owner overrun");
    owner_set_a: assert property (mode_grant && $past(mode_req_mode) != 3'h6 |-> owner_valid
        && owner_channel == $past(mode_req_channel)) else $error("owner wrong");
    stop_clear_a: assert property (stop_held |=> stop_active && active_mode == 7'h00)
        else $error("stop not acted on");
    utility_keep_a: assert property (utility_active |=> utility_active) else $error("utility lost");
endmodule

//--- sim/channel_partner_model.sv
// far side: a channel keeps commands active for a while after its grant
`timescale 1ns/10ps
module channel_partner_model
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       mode_grant,
    input  wire logic [1:0] owner_channel,
    input  wire logic [7:0] hold,
    output logic [2:0]      channel_busy
);
    logic [7:0] cnt_reg;
    logic [1:0] ch_reg;
    // busy rises with the grant itself so ownership is never dropped early
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n) cnt_reg <= 8'h00;
        else if (mode_grant) {cnt_reg, ch_reg} <= {hold, owner_channel};
        else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
    assign channel_busy = (cnt_reg != 8'h00) ? (3'h1 << ch_reg)
                        : (mode_grant && hold != 8'h00) ? (3'h1 << owner_channel) : 3'h0;
endmodule

//--- sim/mode_access_channel_arbiter_tb.sv
// self-checking bench of the mode access channel arbiter
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module mode_access_channel_arbiter_tb;
    logic clk_sys = 0, rst_n = 0, vld = 0, slot = 0, alive = 1, ust = 0, lwe = 0, pwe = 0;
    logic [1:0] ch = 0;
    logic [2:0] md = 0, stop = 0, busy;
    logic [15:0] lwd = 0;
    logic [15:0] lk = 0; // lock value the bench last wrote
    logic [31:0] pwd = 0;
    logic [7:0] hold = 0;
    logic grant, refuse, stp, ov, ua;
    logic [6:0] am;
    logic [1:0] oc;
    logic [15:0] lock;
    logic [31:0] pos;
    int failures = 0, checked = 0, seed = 32'h26e9;
    always #5 clk_sys = ~clk_sys;
    mode_access_channel_arbiter uut (.clk_sys(clk_sys), .rst_n(rst_n), .mode_req_valid(vld),
        .mode_req_channel(ch), .mode_req_mode(md), .channel_busy(busy), .stop_req(stop),
        .expansion_slot_one_present(slot), .fieldbus_alive(alive), .utility_start(ust),
        .lock_wr_en(lwe), .lock_wr_data(lwd), .pos_wr_en(pwe), .pos_wr_data(pwd),
        .mode_grant(grant), .mode_refuse(refuse), .stop_active(stp), .active_mode(am),
        .owner_valid(ov), .owner_channel(oc), .channel_access_lock(lock),
        .absolute_target_position(pos), .utility_active(ua));
    channel_partner_model far (.clk_sys(clk_sys), .rst_n(rst_n), .mode_grant(grant),
        .owner_channel(oc), .hold(hold), .channel_busy(busy));
    // expected answer with no busy owner
    function automatic logic ok(logic [1:0] c, logic [2:0] m);
        ok = (m == 3'h0 && c != 2'h3) || (m < 3'h5 && c < 2'h2) || (m == 3'h5 && c == 2'h0);
        if (m == 3'h3 && !slot) ok = 0;
        if (lk == 16'h0001 && c != 2'h1) ok = 0;
    endfunction
    task automatic cyc(int n); repeat (n) @(posedge clk_sys); #1; endtask
    task automatic req(logic [1:0] c, logic [2:0] m, logic e);
        @(posedge clk_sys); vld <= 1; ch <= c; md <= m;
        @(posedge clk_sys); vld <= 0; #1;
        `CHK({grant, refuse}, e ? 2'b10 : 2'b01)
        if (e) `CHK({am, oc}, {7'h01 << m, c})
    endtask
    task automatic wlock(logic [15:0] v);
        lk = v;
        @(posedge clk_sys); lwe <= 1; lwd <= v;
        @(posedge clk_sys); lwe <= 0; #1;
        `CHK(lock, v)
    endtask
    task automatic end_sim;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin #200000; failures++; end_sim; end
    initial
    begin
        cyc(4); rst_n <= 1; cyc(1);
        `CHK({lock, am, ua, ov}, 25'h0)
        for (int k = 0; k < 4; k++)
        begin
            slot <= k[0]; wlock({15'h0, k[1]}); cyc(3);
            for (int i = 0; i < 20; i++)
            begin
                logic [1:0] c;
                logic [2:0] m;
                c = $random(seed); m = $random(seed);
                if (m == 3'h6) m = 3'h7;
                req(c, m, ok(c, m));
            end
            $display("test config %0d done", k);
        end
        wlock(16'h0000);
        hold <= 8'h14; req(2'h1, 3'h2, 1); req(2'h0, 3'h1, 0);
        for (int i = 0; i < 50 && busy != 3'h0; i++) cyc(1);
        cyc(1); `CHK(ov, 1'b0)
        req(2'h0, 3'h1, 1); hold <= 0; $display("test owner done");
        stop <= 3'h4; cyc(4); `CHK({stp, am}, 8'h80)
        stop <= 0; cyc(4); $display("test stop done");
        wlock(16'h0001); alive <= 0; cyc(5); `CHK(lock, 16'h0000)
        lk = 16'h0000;
        alive <= 1; cyc(3); $display("test link done");
        ust <= 1; cyc(1); ust <= 0; cyc(2); `CHK(ua, 1'b1)
        pwd <= $random(seed); pwe <= 1; cyc(1); pwe <= 0; cyc(1); `CHK(pos, pwd)
        $display("test misc done");
        end_sim;
    end
endmodule
bind mode_access_channel_arbiter mode_arbiter_monitor mon (.*);
